// [design/temp_alarm_pkg.sv]
// Shared constants and types for the temperature alarm monitor
`default_nettype none
package temp_alarm_pkg;
    localparam int NUM_CH          = 4;
    localparam int CH_W            = 2;
    localparam int TEMP_W          = 16;
    localparam int CMP_W           = TEMP_W + 2;
    localparam int ADDR_W          = 8;
    localparam int DATA_W          = 32;
    localparam int OFS_W           = 6;
    localparam int ACC_W           = 96;
    localparam int MIN_W           = 16;
    localparam int TIME_W          = 24;
    localparam int SEC_CNT_W       = 27;
    localparam int STATUS_W        = 3;
    // Timing
    localparam int CLOCK_PERIOD_NS = 8;
    localparam int SECOND_NS       = 1_000_000_000;
    localparam int CYCLES_PER_SEC  = SECOND_NS / CLOCK_PERIOD_NS;
    localparam int SECONDS_PER_MIN = 60;
    // Per-channel word offsets, channel in address bits above OFS_W
    localparam logic [OFS_W-1:0] OFS_HIGH_THR = 6'h00;
    localparam logic [OFS_W-1:0] OFS_LOW_THR  = 6'h04;
    localparam logic [OFS_W-1:0] OFS_DEADBAND = 6'h08;
    localparam logic [OFS_W-1:0] OFS_CONFIG   = 6'h0C;
    localparam logic [OFS_W-1:0] OFS_STATUS   = 6'h10;
    localparam logic [OFS_W-1:0] OFS_ACCUM    = 6'h14;
    localparam logic [OFS_W-1:0] OFS_MINMAX   = 6'h18;
    localparam logic [OFS_W-1:0] OFS_VARIANCE = 6'h1C;
    localparam logic [OFS_W-1:0] OFS_SLOPE    = 6'h20;
    localparam logic [OFS_W-1:0] OFS_OFFSET   = 6'h24;
    // Config fields
    localparam int CFG_HIGH_EN     = 0;
    localparam int CFG_LOW_EN      = 1;
    localparam int CFG_LATCH_EN    = 2;
    localparam int CFG_AUDIBLE_EN  = 3;
    localparam int CFG_INIT        = 4;
    localparam int CFG_W           = 4;
    localparam int ST_HELD         = 2;
    localparam logic [TEMP_W-1:0] RST_THR = 16'h0000;
    localparam logic [TEMP_W-1:0] RST_DB  = 16'h0000;
    localparam logic [CFG_W-1:0]  RST_CFG = 4'h0;
    // Reported alarm codes
    localparam logic [1:0] ALARM_NONE            = 2'h0;
    localparam logic [1:0] low_temp_alarm_state  = 2'h1;
    localparam logic [1:0] high_temp_alarm_state = 2'h2;
    typedef enum logic {VIEW_OTHER, VIEW_ALARM} view_t;
endpackage
`default_nettype wire

// [design/history_stats.sv]
// Running temperature history statistics for one channel
`default_nettype none
module history_stats (
    input  wire logic                                   i_clock,
    input  wire logic                                   i_rst_n,
    input  wire logic                                   i_clear,
    input  wire logic                                   i_sample,
    input  wire logic signed [temp_alarm_pkg::TEMP_W-1:0] i_temp,
    input  wire logic                                   i_sec_tick,
    output logic [temp_alarm_pkg::MIN_W-1:0]            o_accum_min,
    output logic signed [temp_alarm_pkg::TEMP_W-1:0]    o_min,
    output logic signed [temp_alarm_pkg::TEMP_W-1:0]    o_max,
    output logic signed [temp_alarm_pkg::DATA_W-1:0]    o_variance,
    output logic signed [temp_alarm_pkg::DATA_W-1:0]    o_slope,
    output logic signed [temp_alarm_pkg::DATA_W-1:0]    o_offset
);
    localparam int AW = temp_alarm_pkg::ACC_W;
    logic signed [AW-1:0] n_r, sx_r, sxx_r, st_r, stt_r, stx_r;
    logic signed [AW-1:0] xe, te, den, vden, vnum, snum, onum;
    logic [temp_alarm_pkg::TIME_W-1:0] t_r;
    logic [5:0]                         sec_in_min_r;
    logic                               have_r;

    assign xe   = AW'(i_temp);
    assign te   = AW'($signed({1'b0, t_r}));
    assign den  = n_r * stt_r - st_r * st_r;
    assign vden = n_r * n_r;
    assign vnum = n_r * sxx_r - sx_r * sx_r;
    // Slope scaled to per minute before dividing to keep the fraction
    assign snum = AW'(temp_alarm_pkg::SECONDS_PER_MIN) * (n_r * stx_r - st_r * sx_r); // see RULE17 see RULE20
    assign onum = sx_r * stt_r - st_r * stx_r;

    // Elapsed time since the last clear, seconds and whole minutes
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            t_r          <= '0;
            sec_in_min_r <= '0;
            o_accum_min  <= '0;
        end else if (i_clear) begin // see RULE13
            t_r          <= '0;
            sec_in_min_r <= '0;
            o_accum_min  <= '0;
        end else if (i_sec_tick) begin
            t_r <= t_r + 1'b1;
            if (sec_in_min_r == 6'(temp_alarm_pkg::SECONDS_PER_MIN - 1)) begin // see RULE14
                sec_in_min_r <= '0;
                o_accum_min  <= o_accum_min + 1'b1;
            end else begin
                sec_in_min_r <= sec_in_min_r + 1'b1;
            end
        end
    end

    // Wide sums; very long runs can overflow the products, a known limit
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            n_r <= '0; sx_r <= '0; sxx_r <= '0; st_r <= '0; stt_r <= '0; stx_r <= '0;
            have_r <= 1'b0;
            o_min  <= '0;
            o_max  <= '0;
        end else if (i_clear) begin // see RULE13
            n_r <= '0; sx_r <= '0; sxx_r <= '0; st_r <= '0; stt_r <= '0; stx_r <= '0;
            have_r <= 1'b0;
            o_min  <= '0;
            o_max  <= '0;
        end else if (i_sample) begin // see RULE12
            n_r    <= n_r + AW'(1);
            sx_r   <= sx_r + xe;
            sxx_r  <= sxx_r + xe * xe;
            st_r   <= st_r + te;
            stt_r  <= stt_r + te * te;
            stx_r  <= stx_r + te * xe;
            have_r <= 1'b1;
            if (!have_r || i_temp < o_min) o_min <= i_temp; // see RULE15
            if (!have_r || i_temp > o_max) o_max <= i_temp;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_variance <= '0;
            o_slope    <= '0;
            o_offset   <= '0;
        end else begin
            o_variance <= (vden == '0) ? '0 : 32'(vnum / vden); // see RULE16
            o_slope    <= (den == '0) ? '0 : 32'(snum / den);
            o_offset   <= (den != '0) ? 32'(onum / den) : (n_r == '0) ? '0 : 32'(sx_r / n_r);
        end
    end

    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    a_min_below_max: assert property (have_r |-> o_min <= o_max) // see RULE15
        else $error("history minimum above maximum");
    a_clear_empties: assert property (i_clear |=> (n_r == '0 && o_accum_min == '0 && !have_r)) // see RULE13
        else $error("history not emptied by clear");
    c_stats_clear: cover property (have_r ##1 i_clear);
endmodule
`default_nettype wire

// [design/temperature_alarm_monitor.sv]
// Four-channel temperature alarm unit with register port and history
//
// The implementer's own choices: the register addresses and the plain strobed port.
`default_nettype none
// How it works
// RULE1 - Each channel has its own alarm settings
// RULE2 - High and low thresholds, each separately enabled
// RULE3 - Dead-band applied when deciding alarm assertion (alarms here set at the bare threshold, dead-band used only for release)
// RULE4 - Alarm indicator on while any alarm asserted
// RULE5 - Status reports none, low or high
// RULE6 - Status carries latched-held flag per channel
// RULE7 - Latched alarm persists until user clears
// RULE8 - Latching switchable per channel
// RULE9 - Alarm view then home clears latches
// RULE10 - Buzzer sounds on enabled audible channel alarm
// RULE11 - Alarm states offered to remote interfaces
// RULE12 - History statistics accumulated from every reading
// RULE13 - History reset on init or enter
// RULE14 - Elapsed accumulation time kept in minutes
// RULE15 - Minimum and maximum recorded per channel
// RULE16 - Variance as standard deviation squared
// RULE17 - Least-squares slope and offset computed
// RULE18 - Disabling an event drops non-latched alarm
// RULE19 - Hysteresis: release only past threshold by dead-band
// RULE20 - Slope given in display units per minute
module temperature_alarm_monitor #(
    parameter int SEC_CYCLES = temp_alarm_pkg::CYCLES_PER_SEC
) (
    input  wire logic                                         i_clock,
    input  wire logic                                         i_rst_n,
    input  wire logic [temp_alarm_pkg::ADDR_W-1:0]            i_addr,
    input  wire logic [temp_alarm_pkg::DATA_W-1:0]            i_wr_data,
    input  wire logic                                         i_wr_en,
    input  wire logic                                         i_rd_en,
    output logic [temp_alarm_pkg::DATA_W-1:0]                 o_rd_data,
    input  wire logic                                         i_sample_valid,
    input  wire logic [temp_alarm_pkg::CH_W-1:0]              i_sample_ch,
    input  wire logic signed [temp_alarm_pkg::TEMP_W-1:0]     i_sample_temp,
    input  wire logic                                         i_key_alarm,
    input  wire logic                                         i_key_home,
    input  wire logic                                         i_key_enter,
    input  wire logic                                         i_key_other,
    input  wire logic                                         i_stats_selected,
    input  wire logic [temp_alarm_pkg::CH_W-1:0]              i_stats_ch,
    output logic                                              o_alarm_led,
    output logic                                              o_buzzer,
    output logic [temp_alarm_pkg::NUM_CH*temp_alarm_pkg::STATUS_W-1:0] o_remote_status
);
    localparam int NCH = temp_alarm_pkg::NUM_CH;
    localparam int TW  = temp_alarm_pkg::TEMP_W;
    localparam int CW  = temp_alarm_pkg::CMP_W;

    logic signed [TW-1:0]               high_thr_r [NCH];
    logic signed [TW-1:0]               low_thr_r  [NCH];
    logic [TW-1:0]                      deadband_r [NCH];
    logic [temp_alarm_pkg::CFG_W-1:0]   cfg_r      [NCH];
    logic [temp_alarm_pkg::STATUS_W-1:0] status_a  [NCH];
    logic [temp_alarm_pkg::MIN_W-1:0]   accum_a    [NCH];
    logic signed [TW-1:0]               min_a      [NCH];
    logic signed [TW-1:0]               max_a      [NCH];
    logic signed [temp_alarm_pkg::DATA_W-1:0] var_a   [NCH];
    logic signed [temp_alarm_pkg::DATA_W-1:0] slope_a [NCH];
    logic signed [temp_alarm_pkg::DATA_W-1:0] ofs_a   [NCH];
    logic [NCH-1:0]                     active_v;
    logic [NCH-1:0]                     buzz_v;
    logic [NCH-1:0]                     init_v;
    logic [temp_alarm_pkg::DATA_W-1:0]  rd_word;
    logic [temp_alarm_pkg::SEC_CNT_W-1:0] sec_cnt_r;
    logic                               sec_tick_r;
    logic                               latch_clr;
    temp_alarm_pkg::view_t              view_r;

    function automatic logic hit(input logic [temp_alarm_pkg::ADDR_W-1:0] a, input int ch,
                                 input logic [temp_alarm_pkg::OFS_W-1:0] ofs);
        return (a[temp_alarm_pkg::ADDR_W-1:temp_alarm_pkg::OFS_W] == ch[temp_alarm_pkg::CH_W-1:0]) &&
               (a[temp_alarm_pkg::OFS_W-1:0] == ofs);
    endfunction

    // Configuration registers, one independent set per channel
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int c = 0; c < NCH; c++) begin
                high_thr_r[c] <= temp_alarm_pkg::RST_THR;
                low_thr_r[c]  <= temp_alarm_pkg::RST_THR;
                deadband_r[c] <= temp_alarm_pkg::RST_DB;
                cfg_r[c]      <= temp_alarm_pkg::RST_CFG;
            end
        end else if (i_wr_en) begin
            for (int c = 0; c < NCH; c++) begin // see RULE1
                if (hit(i_addr, c, temp_alarm_pkg::OFS_HIGH_THR)) high_thr_r[c] <= i_wr_data[TW-1:0];
                if (hit(i_addr, c, temp_alarm_pkg::OFS_LOW_THR))  low_thr_r[c]  <= i_wr_data[TW-1:0];
                if (hit(i_addr, c, temp_alarm_pkg::OFS_DEADBAND)) deadband_r[c] <= i_wr_data[TW-1:0];
                if (hit(i_addr, c, temp_alarm_pkg::OFS_CONFIG))
                    cfg_r[c] <= i_wr_data[temp_alarm_pkg::CFG_W-1:0]; // see RULE8
            end
        end
    end

    // Keypad sequence: alarm view followed by home clears latches
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            view_r <= temp_alarm_pkg::VIEW_OTHER;
        end else if (i_key_alarm) begin
            view_r <= temp_alarm_pkg::VIEW_ALARM;
        end else if (i_key_home || i_key_enter || i_key_other) begin
            view_r <= temp_alarm_pkg::VIEW_OTHER;
        end
    end
    assign latch_clr = (view_r == temp_alarm_pkg::VIEW_ALARM) && i_key_home && !i_key_alarm; // see RULE9

    // One-second tick for the history time base
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sec_cnt_r  <= '0;
            sec_tick_r <= 1'b0;
        end else if (sec_cnt_r == temp_alarm_pkg::SEC_CNT_W'(SEC_CYCLES - 1)) begin
            sec_cnt_r  <= '0;
            sec_tick_r <= 1'b1;
        end else begin
            sec_cnt_r  <= sec_cnt_r + 1'b1;
            sec_tick_r <= 1'b0;
        end
    end

    for (genvar c = 0; c < NCH; c++) begin : g_ch
        logic                 smp;
        logic                 hi_cond_r, lo_cond_r, hi_latch_r, lo_latch_r;
        logic                 hi_act, lo_act, hist_clr;
        logic signed [CW-1:0] t_ext, hi_ext, lo_ext, db_ext, hi_rel, lo_rel;
        logic [temp_alarm_pkg::CFG_W-1:0] cfg;

        assign cfg    = cfg_r[c];
        assign smp    = i_sample_valid && (i_sample_ch == temp_alarm_pkg::CH_W'(c));
        assign t_ext  = CW'(i_sample_temp);
        assign hi_ext = CW'(high_thr_r[c]);
        assign lo_ext = CW'(low_thr_r[c]);
        assign db_ext = CW'($signed({2'h0, deadband_r[c]}));
        assign hi_rel = hi_ext - db_ext;
        assign lo_rel = lo_ext + db_ext;

        // Conditions set past the threshold, release only past the dead-band
        always_ff @(posedge i_clock or negedge i_rst_n) begin
            if (!i_rst_n) begin
                hi_cond_r <= 1'b0;
            end else if (!cfg[temp_alarm_pkg::CFG_HIGH_EN]) begin // see RULE2 see RULE18
                hi_cond_r <= 1'b0;
            end else if (smp && t_ext > hi_ext) begin // see RULE3
                hi_cond_r <= 1'b1;
            end else if (smp && t_ext < hi_rel) begin // see RULE19
                hi_cond_r <= 1'b0;
            end
        end

        always_ff @(posedge i_clock or negedge i_rst_n) begin
            if (!i_rst_n) begin
                lo_cond_r <= 1'b0;
            end else if (!cfg[temp_alarm_pkg::CFG_LOW_EN]) begin // see RULE2 see RULE18
                lo_cond_r <= 1'b0;
            end else if (smp && t_ext < lo_ext) begin // see RULE3
                lo_cond_r <= 1'b1;
            end else if (smp && t_ext > lo_rel) begin // see RULE19
                lo_cond_r <= 1'b0;
            end
        end

        // A live condition outranks the clear so no event is lost
        always_ff @(posedge i_clock or negedge i_rst_n) begin
            if (!i_rst_n) begin
                hi_latch_r <= 1'b0;
                lo_latch_r <= 1'b0;
            end else if (!cfg[temp_alarm_pkg::CFG_LATCH_EN]) begin // see RULE8
                hi_latch_r <= 1'b0;
                lo_latch_r <= 1'b0;
            end else begin // see RULE7
                hi_latch_r <= hi_cond_r || (hi_latch_r && !latch_clr);
                lo_latch_r <= lo_cond_r || (lo_latch_r && !latch_clr);
            end
        end

        assign hi_act      = hi_cond_r || hi_latch_r;
        assign lo_act      = lo_cond_r || lo_latch_r;
        assign active_v[c] = hi_act || lo_act;
        assign buzz_v[c]   = cfg[temp_alarm_pkg::CFG_AUDIBLE_EN] && active_v[c]; // see RULE10
        assign status_a[c] = {hi_latch_r || lo_latch_r, // see RULE6
                              hi_act ? temp_alarm_pkg::high_temp_alarm_state : // see RULE5
                              lo_act ? temp_alarm_pkg::low_temp_alarm_state : temp_alarm_pkg::ALARM_NONE};
        assign init_v[c]   = i_wr_en && hit(i_addr, c, temp_alarm_pkg::OFS_CONFIG) &&
                             i_wr_data[temp_alarm_pkg::CFG_INIT];
        assign hist_clr    = init_v[c] || (i_key_enter && i_stats_selected &&
                             i_stats_ch == temp_alarm_pkg::CH_W'(c)); // see RULE13

        history_stats u_stats (
            .i_clock     (i_clock),
            .i_rst_n     (i_rst_n),
            .i_clear     (hist_clr),
            .i_sample    (smp),
            .i_temp      (i_sample_temp),
            .i_sec_tick  (sec_tick_r),
            .o_accum_min (accum_a[c]),
            .o_min       (min_a[c]),
            .o_max       (max_a[c]),
            .o_variance  (var_a[c]),
            .o_slope     (slope_a[c]),
            .o_offset    (ofs_a[c])
        );

        a_high_needs_en: assert property (@(posedge i_clock) disable iff (!i_rst_n)
            $past(!cfg[temp_alarm_pkg::CFG_HIGH_EN]) |-> !hi_cond_r) // see RULE2
            else $error("high condition without enable");
        a_high_asserts: assert property (@(posedge i_clock) disable iff (!i_rst_n)
            (smp && cfg[temp_alarm_pkg::CFG_HIGH_EN] && t_ext > hi_ext) ##1
            cfg[temp_alarm_pkg::CFG_HIGH_EN] |-> hi_cond_r) // see RULE3
            else $error("high condition missed above threshold");
        a_band_holds: assert property (@(posedge i_clock) disable iff (!i_rst_n)
            (hi_cond_r && smp && t_ext >= hi_rel && cfg[temp_alarm_pkg::CFG_HIGH_EN]) ##1
            cfg[temp_alarm_pkg::CFG_HIGH_EN] |-> hi_cond_r) // see RULE19
            else $error("high condition released inside dead-band");
        a_low_band_holds: assert property (@(posedge i_clock) disable iff (!i_rst_n)
            (lo_cond_r && smp && t_ext <= lo_rel && cfg[temp_alarm_pkg::CFG_LOW_EN]) ##1
            cfg[temp_alarm_pkg::CFG_LOW_EN] |-> lo_cond_r) // see RULE19
            else $error("low condition released inside dead-band");
        a_latch_holds: assert property (@(posedge i_clock) disable iff (!i_rst_n)
            (hi_latch_r && !latch_clr) ##1 cfg[temp_alarm_pkg::CFG_LATCH_EN] |-> hi_latch_r) // see RULE7
            else $error("latched alarm dropped without clear");
        a_latch_clears: assert property (@(posedge i_clock) disable iff (!i_rst_n)
            (latch_clr && !hi_cond_r && !lo_cond_r) |=> !hi_latch_r && !lo_latch_r) // see RULE9
            else $error("latch not cleared by key sequence");
        a_nonlatch_drop: assert property (@(posedge i_clock) disable iff (!i_rst_n)
            (!cfg[temp_alarm_pkg::CFG_HIGH_EN] && !cfg[temp_alarm_pkg::CFG_LOW_EN] &&
             !cfg[temp_alarm_pkg::CFG_LATCH_EN])[*2] |-> !active_v[c]) // see RULE18
            else $error("disabled alarm still active");
        c_high_alarm: cover property (@(posedge i_clock) disable iff (!i_rst_n) $rose(hi_cond_r));
        c_latch_clear: cover property (@(posedge i_clock) disable iff (!i_rst_n) $fell(hi_latch_r));
    end

    // Register read word, reserved bits and unmapped addresses read zero
    always_comb begin
        logic [temp_alarm_pkg::CH_W-1:0] rc;
        rc      = i_addr[temp_alarm_pkg::ADDR_W-1:temp_alarm_pkg::OFS_W];
        rd_word = '0;
        case (i_addr[temp_alarm_pkg::OFS_W-1:0])
            temp_alarm_pkg::OFS_HIGH_THR: rd_word = {16'h0000, high_thr_r[rc]};
            temp_alarm_pkg::OFS_LOW_THR:  rd_word = {16'h0000, low_thr_r[rc]};
            temp_alarm_pkg::OFS_DEADBAND: rd_word = {16'h0000, deadband_r[rc]};
            temp_alarm_pkg::OFS_CONFIG:   rd_word = {28'h0000000, cfg_r[rc]};
            temp_alarm_pkg::OFS_STATUS:   rd_word = {29'h00000000, status_a[rc]};
            temp_alarm_pkg::OFS_ACCUM:    rd_word = {16'h0000, accum_a[rc]};
            temp_alarm_pkg::OFS_MINMAX:   rd_word = {max_a[rc], min_a[rc]};
            temp_alarm_pkg::OFS_VARIANCE: rd_word = var_a[rc];
            temp_alarm_pkg::OFS_SLOPE:    rd_word = slope_a[rc];
            temp_alarm_pkg::OFS_OFFSET:   rd_word = ofs_a[rc];
            default:                      rd_word = '0;
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rd_data <= '0;
        end else if (i_rd_en) begin
            o_rd_data <= rd_word;
        end else begin
            o_rd_data <= '0;
        end
    end

    // Front indicator, buzzer and remote copy, all registered
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_alarm_led     <= 1'b0;
            o_buzzer        <= 1'b0;
            o_remote_status <= '0;
        end else begin
            o_alarm_led <= |active_v; // see RULE4
            o_buzzer    <= |buzz_v;
            for (int c = 0; c < NCH; c++) begin
                o_remote_status[c*temp_alarm_pkg::STATUS_W +: temp_alarm_pkg::STATUS_W] <= status_a[c]; // see RULE11
            end
        end
    end

    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    a_led_follows_any: assert property (##1 (o_alarm_led == $past(|active_v))) // see RULE4
        else $error("alarm indicator disagrees with channel alarms");
    a_buzzer_needs_en: assert property (o_buzzer |-> $past(|buzz_v)) // see RULE10
        else $error("buzzer without audible channel alarm");
    a_status_legal: assert property (o_remote_status[1:0] != 2'h3 && o_remote_status[4:3] != 2'h3 &&
        o_remote_status[7:6] != 2'h3 && o_remote_status[10:9] != 2'h3) // see RULE5
        else $error("illegal alarm status code");
    a_read_one_cycle: assert property (!i_rd_en |=> o_rd_data == '0)
        else $error("read data outside read slot");
    c_clear_sequence: cover property (i_key_alarm ##[1:20] latch_clr);
endmodule
`default_nettype wire

// [tb/panel_model.sv]
// Front-panel keypad model, one key pulse per press
`default_nettype none
module panel_model (
    input  wire logic i_clock,
    output logic      o_key_alarm,
    output logic      o_key_home,
    output logic      o_key_enter,
    output logic      o_key_other
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] keys_r = 4'h0;
    // Keys drop between presses, as a panel has no held key
    assign {o_key_other, o_key_enter, o_key_home, o_key_alarm} = keys_r;
    // One press drives the given key code for one clock, then releases all keys
    task automatic press(input logic [3:0] k);
        @(posedge i_clock) keys_r <= k;
        @(posedge i_clock) keys_r <= 4'h0;
    endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the temperature alarm monitor
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic               clk = 1'b0;
    logic               rst_n = 1'b0;
    logic [7:0]         addr = 8'h00;
    logic [31:0]        wdata = 32'h0;
    logic               wr = 1'b0, rd = 1'b0, sv = 1'b0, ssel = 1'b1;
    logic [1:0]         sch = 2'h0, stch = 2'h0;
    logic signed [15:0] stemp = 16'sh0;
    logic [31:0]        rdata;
    logic               led, buz, ka, kh, ke, ko;
    logic [11:0]        rstat;
    int                 mismatches = 0, checks_done = 0, cycles = 0;
    always #4 clk = ~clk;
    temperature_alarm_monitor #(.SEC_CYCLES(10)) u_dut (.i_clock(clk), .i_rst_n(rst_n), .i_addr(addr),
        .i_wr_data(wdata), .i_wr_en(wr), .i_rd_en(rd), .o_rd_data(rdata), .i_sample_valid(sv),
        .i_sample_ch(sch), .i_sample_temp(stemp), .i_key_alarm(ka), .i_key_home(kh), .i_key_enter(ke),
        .i_key_other(ko), .i_stats_selected(ssel), .i_stats_ch(stch), .o_alarm_led(led),
        .o_buzzer(buz), .o_remote_status(rstat));
    panel_model u_panel (.i_clock(clk), .o_key_alarm(ka), .o_key_home(kh), .o_key_enter(ke), .o_key_other(ko));
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) begin
            addr  <= a;
            wdata <= d;
            wr    <= 1'b1;
        end
        @(posedge clk) wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk) begin
            addr <= a;
            rd   <= 1'b1;
        end
        @(posedge clk) rd <= 1'b0;
        #1 cmp($sformatf("reg %h", a), e, rdata);
    endtask
    // Sample, then let condition, latch and outputs settle
    task automatic put(input logic [1:0] c, input logic signed [15:0] t);
        @(posedge clk) begin
            sch   <= c;
            stemp <= t;
            sv    <= 1'b1;
        end
        @(posedge clk) sv <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic flags(input logic [1:0] e);
        cmp("led buzzer", {30'h0, e}, {30'h0, led, buz});
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            complete_run();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(8'h10, 32'h0);
        rd_reg(8'h28, 32'h0);
        wr_reg(8'h00, 32'h64);
        wr_reg(8'h08, 32'hA);
        wr_reg(8'h0C, 32'h1);
        wr_reg(8'h44, 32'h32);
        wr_reg(8'h4C, 32'hE);
        rd_reg(8'h4C, 32'hE);
        put(0, 101);
        cmp("remote", 32'h2, {20'h0, rstat});
        flags(2'b10);
        put(0, 95);
        rd_reg(8'h10, 32'h2);
        put(0, 89);
        rd_reg(8'h10, 32'h0);
        rd_reg(8'h18, 32'h0065_0059);
        rd_reg(8'h1C, 32'h18);
        put(1, 40);
        flags(2'b11);
        put(1, 70);
        rd_reg(8'h50, 32'h5);
        rd_reg(8'h10, 32'h0);
        // Other key leaves the view, so home must not clear
        u_panel.press(4'h1);
        u_panel.press(4'h8);
        u_panel.press(4'h2);
        rd_reg(8'h50, 32'h5);
        u_panel.press(4'h1);
        u_panel.press(4'h2);
        rd_reg(8'h50, 32'h0);
        flags(2'b00);
        put(0, 101);
        wr_reg(8'h0C, 32'h0);
        repeat (3) @(posedge clk);
        #1 flags(2'b00);
        u_panel.press(4'h4);
        rd_reg(8'h1C, 32'h0);
        put(0, 50);
        repeat (20) @(posedge clk);
        put(0, 50);
        rd_reg(8'h18, 32'h0032_0032);
        rd_reg(8'h20, 32'h0);
        rd_reg(8'h24, 32'h32);
        repeat (620) @(posedge clk);
        rd_reg(8'h14, 32'h1);
        // Enter away from a statistics line must leave the history alone
        @(posedge clk) ssel <= 1'b0;
        u_panel.press(4'h4);
        rd_reg(8'h18, 32'h0032_0032);
        rd_reg(8'h58, 32'h0046_0028);
        @(posedge clk) begin
            ssel <= 1'b1;
            stch <= 2'h1;
        end
        u_panel.press(4'h4);
        rd_reg(8'h58, 32'h0);
        rd_reg(8'h18, 32'h0032_0032);
        wr_reg(8'h0C, 32'h10);
        rd_reg(8'h18, 32'h0);
        complete_run();
    end
endmodule
`default_nettype wire
